// >>> crf_register_file.sv
//
// Functional notes
// - Sixteen 32-bit general registers, each usable as data or address.
// - General register zero is the stack pointer currently selected.
// - Status word stack-select bit picks user or interrupt stack pointer.
// - Exception table base gives vector table start; keep 4-byte aligned.
// - Interrupt table base gives interrupt vector table start for fetches.
// - Program counter holds the address of the executing instruction.
// - Fast interrupt copies program counter into backup program counter.
// - Fast interrupt copies status word into backup status, same layout.
// - Fast interrupt branches to the fast interrupt vector address.
// - Each float exception, enabled or masked, sets its matching cause flag.
// - Masked float exception sets sticky flag held until software clears.
// - Each accumulator stores 72 bits, presented as 96 bits.
// - Bits 95..72 read as sign of bit 71; writes there dropped.
// - Multiply and multiply-accumulate overwrite accumulator zero.
// - Three slice writes: bits 95..64, 63..32, 31..0.
// - Four slice reads: 95..64, 63..32, 47..16, 31..0.
//
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"

module crf_register_file
	import crf_pkg::*;
#(
	parameter int NUM_GPR = `CRF_NUM_GPR,
	parameter int DATA_W  = `CRF_DATA_W,
	parameter int ACC_W   = `CRF_ACC_W
) (
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	// General register read ports
	input  wire logic [3:0]           gprRdAddrA,
	input  wire logic [3:0]           gprRdAddrB,
	output logic      [DATA_W-1:0]    gprRdDataA,
	output logic      [DATA_W-1:0]    gprRdDataB,
	// General register write port
	input  wire logic                 gprWrEn,
	input  wire logic [3:0]           gprWrAddr,
	input  wire logic [DATA_W-1:0]    gprWrData,
	// Control register access
	input  wire logic                 ctrlWrEn,
	input  wire crf_ctrl_sel_t        ctrlWrSel,
	input  wire logic [DATA_W-1:0]    ctrlWrData,
	input  wire crf_ctrl_sel_t        ctrlRdSel,
	output logic      [DATA_W-1:0]    ctrlRdData,
	// Program counter
	input  wire logic                 pcLoadEn,
	input  wire logic [DATA_W-1:0]    pcLoadData,
	output logic      [DATA_W-1:0]    programCounter,
	// Fast interrupt
	input  wire logic                 fastIntTake,
	// Float status
	input  wire logic                 fpxValid,
	input  wire logic [4:0]           fpxKinds,
	input  wire logic                 fpswWrEn,
	input  wire logic [DATA_W-1:0]    fpswWrData,
	output logic      [DATA_W-1:0]    floatStatusWord,
	// Accumulators
	input  wire logic                 accSel,
	input  wire logic                 accSliceWrEn,
	input  wire crf_slice_t           accSliceWrSel,
	input  wire logic [DATA_W-1:0]    accSliceWrData,
	input  wire crf_slice_t           accSliceRdSel,
	output logic      [DATA_W-1:0]    accSliceRdData,
	input  wire logic                 mulWrEn,
	input  wire logic [ACC_W-1:0]     mulWrData,
	output logic      [ACC_W-1:0]     accumulatorZero,
	// Visible state
	output logic      [DATA_W-1:0]    processorStatusWord,
	output logic      [DATA_W-1:0]    stackPointer,
	output logic      [DATA_W-1:0]    exceptionTableBase,
	output logic      [DATA_W-1:0]    interruptTableBase
);

	// -----------------------------
	// State
	// -----------------------------
	logic [DATA_W-1:0] gpr_q [1:NUM_GPR-1];
	logic [DATA_W-1:0] usp_q, isp_q, psw_q, pc_q, bpc_q, backup_status_word_q, fast_interrupt_vector_q;
	logic [DATA_W-1:0] interrupt_table_base_q, exception_table_base_q, float_status_word_q;
	logic [DATA_W-1:0] gprRdA_q, gprRdB_q, ctrlRd_q, accRd_q;
	logic [DATA_W-1:0] pswNext, fpswNext;
	logic              stackSelNext;
	logic [DATA_W-1:0] spNext;
	logic [DATA_W-1:0] uspNext, ispNext;
	logic [DATA_W-1:0] rdSliceA, rdSliceB;
	logic [ACC_W-1:0]  acc0Value, acc1Value;
	logic              pswWr;

	assign pswWr = ctrlWrEn && ctrlWrSel == CRF_CR_PSW;

	// -----------------------------
	// Status word
	// -----------------------------
	// Next status value is used by stack selection in the same edge
	always_comb begin
		pswNext = psw_q;
		if (pswWr) begin
			pswNext = ctrlWrData;
		end
	end

	assign stackSelNext = pswNext[`CRF_PSW_STACK_SEL_BIT];

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			psw_q <= `CRF_RESET_WORD;
		end else begin
			psw_q <= pswNext;
		end
	end

	// -----------------------------
	// Stack pointers
	// -----------------------------
	// Write to register zero goes to whichever pointer the current select names
	always_comb begin
		uspNext = usp_q;
		ispNext = isp_q;
		if (gprWrEn && gprWrAddr == 4'h0) begin
			if (psw_q[`CRF_PSW_STACK_SEL_BIT]) begin
				uspNext = gprWrData;
			end else begin
				ispNext = gprWrData;
			end
		end
		if (ctrlWrEn && ctrlWrSel == CRF_CR_USP) begin
			uspNext = ctrlWrData;
		end
		if (ctrlWrEn && ctrlWrSel == CRF_CR_ISP) begin
			ispNext = ctrlWrData;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			usp_q <= `CRF_RESET_WORD;
			isp_q <= `CRF_RESET_WORD;
		end else begin
			usp_q <= uspNext;
			isp_q <= ispNext;
		end
	end

	// -----------------------------
	// General registers 1..15
	// -----------------------------
	genvar gi;
	generate
		for (gi = 1; gi < NUM_GPR; gi++) begin : g_gpr
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					gpr_q[gi] <= `CRF_RESET_WORD;
				end else if (gprWrEn && gprWrAddr == 4'(gi)) begin
					gpr_q[gi] <= gprWrData;
				end
			end
		end
	endgenerate

	// Stack pointer as seen after this edge, so a select change is never stale
	// Both pointers' next values are used, so a same-edge r0 write shows unless a PSW write flips the select or a USP or ISP write to it replaces it
	always_comb begin
		spNext = stackSelNext ? uspNext : ispNext;
	end

	// Registered reads see the state after this edge
	always_comb begin
		rdSliceA = (gprRdAddrA == 4'h0) ? spNext : gpr_q[gprRdAddrA == 4'h0 ? 1 : gprRdAddrA];
		if (gprRdAddrA != 4'h0 && gprWrEn && gprWrAddr == gprRdAddrA) begin
			rdSliceA = gprWrData;
		end
		rdSliceB = (gprRdAddrB == 4'h0) ? spNext : gpr_q[gprRdAddrB == 4'h0 ? 1 : gprRdAddrB];
		if (gprRdAddrB != 4'h0 && gprWrEn && gprWrAddr == gprRdAddrB) begin
			rdSliceB = gprWrData;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gprRdA_q <= `CRF_RESET_WORD;
			gprRdB_q <= `CRF_RESET_WORD;
		end else begin
			gprRdA_q <= rdSliceA;
			gprRdB_q <= rdSliceB;
		end
	end

	// -----------------------------
	// Table bases and fast interrupt vector
	// -----------------------------
	// Alignment is software's concern; low bits are stored as written
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			exception_table_base_q  <= `CRF_RESET_WORD;
			interrupt_table_base_q  <= `CRF_RESET_WORD;
			fast_interrupt_vector_q <= `CRF_RESET_WORD;
		end else if (ctrlWrEn) begin
			if (ctrlWrSel == CRF_CR_EXCEPTION_TABLE_BASE) begin
				exception_table_base_q <= ctrlWrData;
			end else if (ctrlWrSel == CRF_CR_INTERRUPT_TABLE_BASE) begin
				interrupt_table_base_q <= ctrlWrData;
			end else if (ctrlWrSel == CRF_CR_FAST_INTERRUPT_VECTOR) begin
				fast_interrupt_vector_q <= ctrlWrData;
			end
		end
	end

	// -----------------------------
	// Program counter and fast interrupt backup
	// -----------------------------
	// Fast interrupt outranks a branch load in the same cycle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pc_q <= `CRF_RESET_WORD;
		end else if (fastIntTake) begin
			pc_q <= fast_interrupt_vector_q;
		end else if (pcLoadEn) begin
			pc_q <= pcLoadData;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bpc_q  <= `CRF_RESET_WORD;
			backup_status_word_q <= `CRF_RESET_WORD;
		end else if (fastIntTake) begin
			bpc_q  <= pc_q;
			backup_status_word_q <= psw_q;
		end else if (ctrlWrEn) begin
			if (ctrlWrSel == CRF_CR_BPC) begin
				bpc_q <= ctrlWrData;
			end else if (ctrlWrSel == CRF_CR_BACKUP_STATUS_WORD) begin
				backup_status_word_q <= ctrlWrData;
			end
		end
	end

	// -----------------------------
	// Float status word
	// -----------------------------
	// Hardware set wins over a software clear in the same cycle
	always_comb begin
		fpswNext = float_status_word_q;
		if (fpswWrEn) begin
			fpswNext = fpswWrData;
		end
		if (fpxValid) begin
			for (int k = 0; k < `CRF_FPX_KINDS; k++) begin
				fpswNext[`CRF_FLOAT_STATUS_WORD_CAUSE_LSB + k] = fpxKinds[k];
				if (fpxKinds[k] && !float_status_word_q[`CRF_FLOAT_STATUS_WORD_ENABLE_LSB + k]) begin
					fpswNext[`CRF_FLOAT_STATUS_WORD_STICKY_LSB + k] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			float_status_word_q <= `CRF_RESET_WORD;
		end else begin
			float_status_word_q <= fpswNext;
		end
	end

	// -----------------------------
	// Accumulators
	// -----------------------------
	logic [DATA_W-1:0] acc0Slice, acc1Slice;

	crf_accumulator #(
		.ACC_W (ACC_W)
	) u_dsp_accumulator_0 (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.sliceWrEn   (accSliceWrEn && !accSel),
		.sliceWrSel  (accSliceWrSel),
		.sliceWrData (accSliceWrData),
		.fullWrEn    (mulWrEn),
		.fullWrData  (mulWrData),
		.sliceRdSel  (accSliceRdSel),
		.sliceRdData (acc0Slice),
		.accValue    (acc0Value)
	);

	crf_accumulator #(
		.ACC_W (ACC_W)
	) u_dsp_accumulator_1 (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.sliceWrEn   (accSliceWrEn && accSel),
		.sliceWrSel  (accSliceWrSel),
		.sliceWrData (accSliceWrData),
		.fullWrEn    (1'b0),
		.fullWrData  (mulWrData),
		.sliceRdSel  (accSliceRdSel),
		.sliceRdData (acc1Slice),
		.accValue    (acc1Value)
	);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			accRd_q <= `CRF_RESET_WORD;
		end else begin
			accRd_q <= accSel ? acc1Slice : acc0Slice;
		end
	end

	// -----------------------------
	// Control register read
	// -----------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrlRd_q <= `CRF_RESET_WORD;
		end else begin
			case (ctrlRdSel)
				CRF_CR_PSW:   ctrlRd_q <= psw_q;
				CRF_CR_USP:   ctrlRd_q <= usp_q;
				CRF_CR_ISP:   ctrlRd_q <= isp_q;
				CRF_CR_INTERRUPT_TABLE_BASE:  ctrlRd_q <= interrupt_table_base_q;
				CRF_CR_EXCEPTION_TABLE_BASE:  ctrlRd_q <= exception_table_base_q;
				CRF_CR_BPC:   ctrlRd_q <= bpc_q;
				CRF_CR_BACKUP_STATUS_WORD:  ctrlRd_q <= backup_status_word_q;
				default:      ctrlRd_q <= fast_interrupt_vector_q;
			endcase
		end
	end

	// -----------------------------
	// Outputs
	// -----------------------------
	logic [DATA_W-1:0] sp_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sp_q <= `CRF_RESET_WORD;
		end else begin
			sp_q <= spNext;
		end
	end

	assign gprRdDataA          = gprRdA_q;
	assign gprRdDataB          = gprRdB_q;
	assign ctrlRdData          = ctrlRd_q;
	assign accSliceRdData      = accRd_q;
	assign programCounter      = pc_q;
	assign floatStatusWord     = float_status_word_q;
	assign accumulatorZero     = acc0Value;
	assign processorStatusWord = psw_q;
	assign stackPointer        = sp_q;
	assign exceptionTableBase  = exception_table_base_q;
	assign interruptTableBase  = interrupt_table_base_q;

endmodule

`default_nettype wire

// >>> crf_defs.svh
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// Register file geometry
`define CRF_NUM_GPR      16
`define CRF_DATA_W       32
`define CRF_ACC_W        72
`define CRF_ACC_SIGN_BIT 71

// Status word field positions
`define CRF_PSW_STACK_SEL_BIT 17

// Float status word field positions (cause flags, enables, sticky flags)
`define CRF_FLOAT_STATUS_WORD_CAUSE_LSB  2
`define CRF_FLOAT_STATUS_WORD_ENABLE_LSB 10
`define CRF_FLOAT_STATUS_WORD_STICKY_LSB 26
`define CRF_FPX_KINDS       5

// Reset values
`define CRF_RESET_WORD 32'h0000_0000
`define CRF_RESET_ACC  72'h00_0000_0000_0000_0000

`endif

// >>> crf_pkg.sv
package crf_pkg;

	// Control register selector for move-to / move-from control operations
	typedef enum logic [2:0] {
		CRF_CR_PSW,
		CRF_CR_USP,
		CRF_CR_ISP,
		CRF_CR_INTERRUPT_TABLE_BASE,
		CRF_CR_EXCEPTION_TABLE_BASE,
		CRF_CR_BPC,
		CRF_CR_BACKUP_STATUS_WORD,
		CRF_CR_FAST_INTERRUPT_VECTOR
	} crf_ctrl_sel_t;

	// Accumulator slice selector
	typedef enum logic [1:0] {
		CRF_SLICE_GUARD,
		CRF_SLICE_HIGH,
		CRF_SLICE_MID,
		CRF_SLICE_LOW
	} crf_slice_t;

endpackage

// >>> crf_accumulator.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"

module crf_accumulator
	import crf_pkg::*;
#(
	parameter int ACC_W = `CRF_ACC_W
) (
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	input  wire logic                   sliceWrEn,
	input  wire crf_slice_t             sliceWrSel,
	input  wire logic [`CRF_DATA_W-1:0] sliceWrData,
	input  wire logic                   fullWrEn,
	input  wire logic [ACC_W-1:0]       fullWrData,
	input  wire crf_slice_t             sliceRdSel,
	output logic      [`CRF_DATA_W-1:0] sliceRdData,
	output logic      [ACC_W-1:0]       accValue
);

	logic [ACC_W-1:0] acc_q;
	logic [95:0]      wide;

	// -----------------------------
	// Storage
	// -----------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			acc_q <= `CRF_RESET_ACC;
		end else if (fullWrEn) begin
			acc_q <= fullWrData;
		end else if (sliceWrEn) begin
			case (sliceWrSel)
				// Upper 24 bits of the guard word have no storage
				CRF_SLICE_GUARD: acc_q[71:64] <= sliceWrData[7:0];
				CRF_SLICE_HIGH:  acc_q[63:32] <= sliceWrData;
				CRF_SLICE_LOW:   acc_q[31:0]  <= sliceWrData;
				default:         acc_q        <= acc_q;
			endcase
		end
	end

	// -----------------------------
	// Sign-extended 96-bit view
	// -----------------------------
	assign wide = {{24{acc_q[`CRF_ACC_SIGN_BIT]}}, acc_q};

	always_comb begin
		case (sliceRdSel)
			CRF_SLICE_GUARD: sliceRdData = wide[95:64];
			CRF_SLICE_HIGH:  sliceRdData = wide[63:32];
			CRF_SLICE_MID:   sliceRdData = wide[47:16];
			default:         sliceRdData = wide[31:0];
		endcase
	end

	assign accValue = acc_q;

endmodule

`default_nettype wire

// >>> crf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module crf_checker
	import crf_pkg::*;
(
	input wire logic          mclk,
	input wire logic          sys_rst,
	input wire logic          gprWrEn,
	input wire logic [3:0]    gprWrAddr,
	input wire logic [31:0]   gprWrData,
	input wire logic [3:0]    gprRdAddrA,
	input wire logic [31:0]   gprRdDataA,
	input wire logic          ctrlWrEn,
	input wire crf_ctrl_sel_t ctrlWrSel,
	input wire logic [31:0]   ctrlWrData,
	input wire crf_ctrl_sel_t ctrlRdSel,
	input wire logic [31:0]   ctrlRdData,
	input wire logic          pcLoadEn,
	input wire logic [31:0]   pcLoadData,
	input wire logic [31:0]   programCounter,
	input wire logic          fastIntTake,
	input wire logic          fpxValid,
	input wire logic [4:0]    fpxKinds,
	input wire logic          fpswWrEn,
	input wire logic [31:0]   floatStatusWord,
	input wire logic          mulWrEn,
	input wire logic [71:0]   mulWrData,
	input wire logic [71:0]   accumulatorZero,
	input wire logic [31:0]   processorStatusWord,
	input wire logic [31:0]   stackPointer
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	chk_gpr_write:
		assert property (gprWrEn && gprWrAddr == gprRdAddrA && gprWrAddr != 4'h0 |=> gprRdDataA == $past(gprWrData))
			else $error("gpr readback wrong");
	chk_user_sp:
		assert property (ctrlWrEn && ctrlWrSel == CRF_CR_USP && processorStatusWord[17]
			&& !(gprWrEn && gprWrAddr == 4'h0) |=> stackPointer == $past(ctrlWrData)) else $error("user pointer unused");
	chk_bpc_save:
		assert property (fastIntTake ##1 ctrlRdSel == CRF_CR_BPC |=> ctrlRdData == $past(programCounter, 2))
			else $error("backup pc wrong");
	chk_backup_status_word_save:
		assert property (fastIntTake ##1 ctrlRdSel == CRF_CR_BACKUP_STATUS_WORD |=> ctrlRdData == $past(processorStatusWord, 2))
			else $error("backup status wrong");
	chk_pc_load:
		assert property (pcLoadEn && !fastIntTake |=> programCounter == $past(pcLoadData))
			else $error("pc load lost");
	chk_cause_set:
		assert property (fpxValid && !fpswWrEn |=> floatStatusWord[6:2] == $past(fpxKinds))
			else $error("cause flags wrong");
	chk_sticky_hold:
		assert property (!fpswWrEn |=> &(floatStatusWord[30:26] | ~$past(floatStatusWord[30:26])))
			else $error("sticky flag dropped");
	chk_mul_dest:
		assert property (mulWrEn |=> accumulatorZero == $past(mulWrData))
			else $error("multiply result lost");

	cov_fint: cover property (fastIntTake);
	cov_fpx: cover property (fpxValid);
	cov_mul: cover property (mulWrEn);
	cov_sel_r0: cover property (gprWrEn && gprWrAddr == 4'h0 && ctrlWrEn && ctrlWrSel == CRF_CR_PSW);
endmodule

bind crf_register_file crf_checker i_chk (
	.mclk(mclk), .sys_rst(sys_rst), .gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr), .gprWrData(gprWrData),
	.gprRdAddrA(gprRdAddrA), .gprRdDataA(gprRdDataA), .ctrlWrEn(ctrlWrEn), .ctrlWrSel(ctrlWrSel),
	.ctrlWrData(ctrlWrData), .ctrlRdSel(ctrlRdSel), .ctrlRdData(ctrlRdData), .pcLoadEn(pcLoadEn),
	.pcLoadData(pcLoadData), .programCounter(programCounter), .fastIntTake(fastIntTake), .fpxValid(fpxValid),
	.fpxKinds(fpxKinds), .fpswWrEn(fpswWrEn), .floatStatusWord(floatStatusWord), .mulWrEn(mulWrEn),
	.mulWrData(mulWrData), .accumulatorZero(accumulatorZero), .processorStatusWord(processorStatusWord),
	.stackPointer(stackPointer)
);
`default_nettype wire

// >>> crf_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
module crf_exec_model (
	input  wire logic        mclk,
	output logic [7:0]       en,
	output logic [3:0]       sel,
	output logic [71:0]      data
);
	initial begin
		en = 8'h00;
		sel = 4'h0;
		data = 72'h0;
	end

	// One request held for exactly one taking edge, after an optional stall
	task automatic op(input logic [7:0] e, input logic [3:0] s, input logic [71:0] d, input int gap);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		#1;
		en = e;
		sel = s;
		data = d;
		@(posedge mclk);
		#1;
		en = 8'h00;
		data = ~d; // Idle bus must not echo the last value
	endtask
endmodule
`default_nettype wire

// >>> crf_register_file_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module crf_register_file_tb_top
	import crf_pkg::*;
();
	localparam logic [7:0] GW = 8'h80, CW = 8'h40, PL = 8'h20, FI = 8'h10;
	localparam logic [7:0] FX = 8'h08, FW = 8'h04, AW = 8'h02, MW = 8'h01;
	localparam int SH [4] = '{64, 32, 16, 0};
	logic          mclk = 1'b0;
	logic          sys_rst = 1'b1;
	logic [3:0]    gprRdAddrA = 4'h0;
	logic [3:0]    gprRdAddrB = 4'h0;
	crf_ctrl_sel_t ctrlRdSel = CRF_CR_PSW;
	crf_slice_t    accSliceRdSel = CRF_SLICE_GUARD;
	logic          accSel = 1'b0;
	logic [7:0]    en;
	logic [3:0]    sel;
	logic [71:0]   data;
	logic [31:0]   rdA, rdB, ctrlRd, pc, fsw, accRd, processor_status_word, sp, exception_table_base, interrupt_table_base;
	logic [71:0]   dsp_accumulator_0;
	logic [31:0]   lf = 32'd72943;
	logic [31:0]   cr [8];
	logic [31:0]   gpr [16];
	logic [31:0]   mPc, mFsw;
	logic [71:0]   acc [2];
	int            failures = 0;
	int            n_checks = 0;

	always #10 mclk = ~mclk;

	crf_exec_model i_pipe (.mclk(mclk), .en(en), .sel(sel), .data(data));

	crf_register_file i_dut (
		.mclk(mclk), .sys_rst(sys_rst), .gprRdAddrA(gprRdAddrA), .gprRdAddrB(gprRdAddrB),
		.gprRdDataA(rdA), .gprRdDataB(rdB), .gprWrEn(en[7]), .gprWrAddr(sel), .gprWrData(data[31:0]),
		.ctrlWrEn(en[6]), .ctrlWrSel(crf_ctrl_sel_t'(sel[2:0])), .ctrlWrData(data[31:0]),
		.ctrlRdSel(ctrlRdSel), .ctrlRdData(ctrlRd), .pcLoadEn(en[5]), .pcLoadData(data[31:0]),
		.programCounter(pc), .fastIntTake(en[4]), .fpxValid(en[3]), .fpxKinds(data[4:0]),
		.fpswWrEn(en[2]), .fpswWrData(data[31:0]), .floatStatusWord(fsw), .accSel(accSel),
		.accSliceWrEn(en[1]), .accSliceWrSel(crf_slice_t'(sel[1:0])), .accSliceWrData(data[31:0]),
		.accSliceRdSel(accSliceRdSel), .accSliceRdData(accRd), .mulWrEn(en[0]), .mulWrData(data),
		.accumulatorZero(dsp_accumulator_0), .processorStatusWord(processor_status_word), .stackPointer(sp),
		.exceptionTableBase(exception_table_base), .interruptTableBase(interrupt_table_base)
	);

	function automatic logic [31:0] r();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction

	function automatic logic [31:0] gv(input logic [3:0] a);
		return (a != 4'h0) ? gpr[a] : cr[0][17] ? cr[1] : cr[2];
	endfunction

	task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic mReset();
		foreach (cr[k]) cr[k] = 32'h0;
		foreach (gpr[k]) gpr[k] = 32'h0;
		acc[0] = 72'h0;
		acc[1] = 72'h0;
		mPc = 32'h0;
		mFsw = 32'h0;
	endtask

	task automatic cmpAll();
		chk("pc", pc, mPc);
		chk("psw", processor_status_word, cr[0]);
		chk("sp", sp, gv(4'h0));
		chk("exception_table_base", exception_table_base, cr[4]);
		chk("interrupt_table_base", interrupt_table_base, cr[3]);
		chk("fsw", fsw, mFsw);
		chk("dsp_accumulator_0", dsp_accumulator_0, acc[0]);
	endtask

	// Priority order mirrors the design's same-edge conflicts except that a control write outranks a fast interrupt
	task automatic go(input logic [7:0] e, input logic [3:0] s, input logic [71:0] d);
		i_pipe.op(e, s, d, int'(lf[1:0]));
		// Register zero write follows the select in force before this edge
		if (e[7] && s != 4'h0)
			gpr[s] = d[31:0];
		else if (e[7])
			cr[cr[0][17] ? 1 : 2] = d[31:0];
		case (1'b1)
			e[6]: cr[s[2:0]] = d[31:0];
			e[4]: begin
				cr[5] = mPc;
				cr[6] = cr[0];
				mPc = cr[7];
			end
			e[5]: mPc = d[31:0];
			e[3]: begin
				mFsw[6:2] = d[4:0];
				mFsw[30:26] |= d[4:0] & ~mFsw[14:10];
			end
			e[2]: mFsw = d[31:0];
			e[0]: acc[0] = d;
			e[1]: begin
				if (s[1:0] == 2'd0)
					acc[accSel][71:64] = d[7:0];
				else if (s[1:0] == 2'd1)
					acc[accSel][63:32] = d[31:0];
				else if (s[1:0] == 2'd3)
					acc[accSel][31:0] = d[31:0];
			end
			default: ;
		endcase
		cmpAll();
	endtask

	task automatic rdAll();
		logic [95:0] v;
		for (int i = 0; i < 16; i++) begin
			gprRdAddrA = i[3:0];
			gprRdAddrB = ~i[3:0];
			ctrlRdSel = crf_ctrl_sel_t'(i[2:0]);
			accSel = i[3];
			accSliceRdSel = crf_slice_t'(i[1:0]);
			v = {{24{acc[i[3]][71]}}, acc[i[3]]} >> SH[i[1:0]];
			@(posedge mclk);
			#1;
			chk("gprA", rdA, gv(i[3:0]));
			chk("gprB", rdB, gv(~i[3:0]));
			chk("ctrl", ctrlRd, cr[i[2:0]]);
			chk("slice", accRd, v[31:0]);
		end
	endtask

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		mReset();
		repeat (4) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		cmpAll();
		rdAll();
		for (int i = 0; i < 16; i++) begin
			gprRdAddrA = i[3:0];
			go(GW, i[3:0], r() & 32'hffff_fffc);
		end
		go(CW, 4'h0, 72'h2_0000);
		go(CW, 4'h1, r() & 32'hffff_fffc);
		gprRdAddrA = 4'h0;
		go(GW, 4'h0, r() & 32'hffff_fffc);
		go(GW | CW, 4'h0, r() | 32'h2_0000);
		rdAll();
		for (int k = 0; k < 8; k++)
			go(CW, k[3:0], r() & 32'hffff_fffc);
		for (int k = 5; k < 7; k++) begin
			go(PL, 4'h0, r());
			ctrlRdSel = crf_ctrl_sel_t'(k[2:0]);
			go(FI | PL, 4'h0, r());
			@(posedge mclk);
			#1;
			chk("backup", ctrlRd, cr[k]);
		end
		go(FW, 4'h0, 72'h1400);
		go(FX, 4'h0, 72'h1f);
		go(FX, 4'h0, 72'h00);
		for (int k = 0; k < 6; k++) begin
			go(FW, 4'h0, r());
			go(FX, 4'h0, r());
		end
		for (int k = 0; k < 16; k++) begin
			accSel = k[0];
			go(AW, {2'b00, k[2:1]}, r());
		end
		accSel = 1'b0;
		go(MW | AW, 4'h3, 72'({r(), r(), r()}));
		rdAll();
		sys_rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		mReset();
		cmpAll();
		rdAll();
		results();
	end

	// Hang guard: far above the longest sequence
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		results();
	end
endmodule
`default_nettype wire
